// ### hw/ldc_params.svh
// constants for the display-control command decoder
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
`define LDC_OFF_CMD      12'h000
`define LDC_OFF_STAT0    12'h004
`define LDC_OFF_STAT1    12'h008
`define LDC_OFF_MUX      12'h00C
`define LDC_OFF_ADDR     12'h010
`define LDC_OFF_CFG      12'h014
`define LDC_OFF_GEOM     12'h018
`define LDC_RST_PM       8'h4E
`define LDC_RST_PART     2'b00
`define LDC_RST_AC       3'b001
`define LDC_RST_FIX      8'h00
`define LDC_RST_LR       2'b00
`define LDC_RST_DC       4'b1000
`define LDC_RST_MAP      3'b000
`define LDC_RST_NIV      4'h6
`define LDC_RST_GS1      2'b01
`define LDC_RST_CEN      7'h7F
`define LDC_RST_DST      7'h00
`define LDC_RST_DEN      7'h7F
`define LDC_PM_MAX       8'hC1
`define LDC_CA_LAST      5'h1F
`define LDC_RA_LAST      7'h7F
`define LDC_PWR_UP_US    10
`define LDC_CLK_MHZ      100
`define LDC_PWR_UP_CYC   (`LDC_PWR_UP_US * `LDC_CLK_MHZ)
`endif

// ### hw/ldc_pkg.sv
// types for the display-control command decoder
package ldc_pkg;
	typedef enum logic [1:0] {LDC_PWR_SLEEP, LDC_PWR_PUMP, LDC_PWR_ON} ldc_pwr_t;
	typedef enum logic [2:0] {LDC_PB_NONE, LDC_PB_BIAS, LDC_PB_FIX, LDC_PB_NIV,
		LDC_PB_CEN, LDC_PB_DST, LDC_PB_DEN} ldc_pend_t;
endpackage

// ### hw/ldc_ctrl.sv
// display-control command decoder with apb access and ram address stepping
//
// Notes on behaviour
// R1: command bytes decoded; double-byte takes next parameter
// R2: bias byte stored, effective range 0..193
// R3: partial field 11b narrows mux rate
// R4: auto wrap restarts leading, steps other
// R5: increment order picks leading address
// R6: wrapped row step adds or subtracts one
// R7: no window means default window bounds
// R8: fixed nibbles top/bottom, excluded from scroll
// R9: fixed row placement swaps under vertical flip
// R10: host keeps partial rows clear of icons
// R11: two-bit line rate code, four rates
// R12: line rate scaled by mux rate
// R13: black-and-white mode uses slower rates
// R14: all-on forces segments on
// R15: inverse drives inverted ram data
// R16: enable bit sleeps or wakes power sequence
// R17: shade bit selects mode, auto convert
// R18: host waits after enabling display
// R19: vertical flip reverses row mapping now
// R20: horizontal flip mirrors column address
// R21: icon flag shows fixed section in partial
// R22: inversion parameter: lines, xor, enable
// R23: two-bit gray shade separation field
//
// Decided for this implementation: register access over APB and the register addresses.
`include "ldc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module ldc_ctrl (
	input  wire logic        pclk,         // system clock
	input  wire logic        presetn,      // async reset, low active
	input  wire logic        clk_en,       // freezes state when low
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction
	input  wire logic [11:0] paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic             pready,       // apb ready
	output logic             pslverr,      // unmapped access
	output logic [31:0]      prdata,       // apb read data
	input  wire logic        ram_access,   // one host ram data access
	input  wire logic [1:0]  pix_data,     // raw 2-bit pixel from ram
	output logic [1:0]       seg_level,    // level to segment driver
	output logic             drivers_on,   // common/segment drivers running
	output logic             pump_on,      // voltage generation running
	output logic [6:0]       com_row_map,  // ram row for scanned com
	input  wire logic [6:0]  com_index,    // com being scanned
	output logic [4:0]       ram_col_addr  // physical column address
);
	import ldc_pkg::*;

	logic [7:0] bias_potentiometer_value_r;
	logic [1:0] partial_r;
	logic [3:0] ram_addr_ctrl_r;
	logic [3:0] top_fixed_pairs_r;
	logic [3:0] bottom_fixed_pairs_r;
	logic [1:0] line_rate_r;
	logic [3:0] display_ctrl_bits_r;
	logic [2:0] panel_config_bits_r;
	logic [3:0] line_inversion_cfg_r;
	logic [1:0] gray1_r;
	logic [1:0] gray2_r;
	logic [6:0] last_common_index_r;
	logic [6:0] partial_first_row_r;
	logic [6:0] partial_last_row_r;
	logic [4:0] column_group_pointer_r;
	logic [6:0] row_pointer_r;
	logic [4:0] win_c0_r, win_c1_r;
	logic [6:0] win_r0_r, win_r1_r;
	ldc_pend_t  pend_r;
	ldc_pwr_t   pwr_r;
	logic [9:0] pwr_cnt_r;

	logic       wr_acc;
	logic       cmd_wr;
	logic [7:0] cmd;
	logic [7:0] mux_rate;
	logic [7:0] fixed_rows;
	logic [7:0] lr_rate;

	////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states
	assign pready  = 1'b1;
	assign wr_acc  = psel & penable & pwrite & clk_en;
	assign cmd_wr  = wr_acc & (paddr == `LDC_OFF_CMD);
	assign cmd     = pwdata[7:0];

	// unmapped offsets fail; command register is write-only
	always_comb
	begin
		pslverr = 1'b0;
		if (psel && penable)
		begin
			case (paddr)
				`LDC_OFF_CMD:   pslverr = ~pwrite;
				`LDC_OFF_STAT0, `LDC_OFF_STAT1, `LDC_OFF_MUX,
				`LDC_OFF_ADDR:  pslverr = pwrite;
				`LDC_OFF_CFG, `LDC_OFF_GEOM: pslverr = pwrite;
				default:        pslverr = 1'b1;
			endcase
		end
	end

	// read data registered at setup so it is stable in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite)
		begin
			case (paddr)
				`LDC_OFF_STAT0: prdata <= {6'h00, bias_potentiometer_value_r, 1'b0, pwr_r,
					display_ctrl_bits_r, panel_config_bits_r, ram_addr_ctrl_r,
					line_rate_r, partial_r};
				`LDC_OFF_STAT1: prdata <= {12'h000, gray2_r, gray1_r, line_inversion_cfg_r,
					top_fixed_pairs_r, bottom_fixed_pairs_r, 1'b0, pend_r};
				`LDC_OFF_MUX:   prdata <= {16'h0000, lr_rate, mux_rate};
				`LDC_OFF_ADDR:  prdata <= {15'h0, ram_col_addr, column_group_pointer_r,
					row_pointer_r};
				`LDC_OFF_CFG:   prdata <= {8'h00, win_r1_r, win_r0_r, win_c1_r, win_c0_r};
				`LDC_OFF_GEOM:  prdata <= {11'h0, last_common_index_r, partial_first_row_r,
					partial_last_row_r};
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// R1: parameter capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_r <= LDC_PB_NONE;
		else if (cmd_wr)
		begin
			if (pend_r != LDC_PB_NONE)
				pend_r <= LDC_PB_NONE;
			else if (cmd == 8'h81)
				pend_r <= LDC_PB_BIAS;
			else if (cmd == 8'h90)
				pend_r <= LDC_PB_FIX;
			else if (cmd == 8'hC8)
				pend_r <= LDC_PB_NIV;
			else if (cmd == 8'hF1)
				pend_r <= LDC_PB_CEN;
			else if (cmd == 8'hF2)
				pend_r <= LDC_PB_DST;
			else if (cmd == 8'hF3)
				pend_r <= LDC_PB_DEN;
		end
	end

	// R1: single-byte opcodes and double-byte parameters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bias_potentiometer_value_r <= `LDC_RST_PM;
			partial_r            <= `LDC_RST_PART;
			ram_addr_ctrl_r      <= {1'b0, `LDC_RST_AC};
			top_fixed_pairs_r    <= 4'(`LDC_RST_FIX >> 4);
			bottom_fixed_pairs_r <= 4'(`LDC_RST_FIX);
			line_rate_r          <= `LDC_RST_LR;
			display_ctrl_bits_r  <= `LDC_RST_DC;
			panel_config_bits_r  <= `LDC_RST_MAP;
			line_inversion_cfg_r <= `LDC_RST_NIV;
			gray1_r              <= `LDC_RST_GS1;
			gray2_r              <= 2'b10;
			last_common_index_r  <= `LDC_RST_CEN;
			partial_first_row_r  <= `LDC_RST_DST;
			partial_last_row_r   <= `LDC_RST_DEN;
		end
		else if (cmd_wr)
		begin
			if (pend_r != LDC_PB_NONE)
			begin
				case (pend_r)
					// R2: bias byte
					LDC_PB_BIAS: bias_potentiometer_value_r <= cmd;
					// R8: nibbles split top/bottom
					LDC_PB_FIX:
					begin
						top_fixed_pairs_r    <= cmd[7:4];
						bottom_fixed_pairs_r <= cmd[3:0];
					end
					// R22: inversion parameter
					LDC_PB_NIV:  line_inversion_cfg_r <= cmd[3:0];
					LDC_PB_CEN:  last_common_index_r  <= cmd[6:0];
					LDC_PB_DST:  partial_first_row_r  <= cmd[6:0];
					LDC_PB_DEN:  partial_last_row_r   <= cmd[6:0];
					default:     partial_r <= partial_r;
				endcase
			end
			// R3: partial display field
			else if (cmd[7:2] == 6'b100001)
				partial_r <= cmd[1:0];
			else if (cmd[7:3] == 5'b10001)
				ram_addr_ctrl_r[2:0] <= cmd[2:0];
			else if (cmd[7:1] == 7'b1111100)
				ram_addr_ctrl_r[3] <= cmd[0];
			// R11: line rate code
			else if (cmd[7:2] == 6'b101000)
				line_rate_r <= cmd[1:0];
			// R14: all-on bit
			else if (cmd[7:1] == 7'b1010010)
				display_ctrl_bits_r[1] <= cmd[0];
			// R15: inverse bit
			else if (cmd[7:1] == 7'b1010011)
				display_ctrl_bits_r[0] <= cmd[0];
			// R16: enable and R17: shade mode
			else if (cmd[7:2] == 6'b101011)
				display_ctrl_bits_r[3:2] <= cmd[1:0];
			// R19: flips and R21: icon flag
			else if (cmd[7:3] == 5'b11000)
				panel_config_bits_r <= cmd[2:0];
			// R23: gray shade field
			else if (cmd[7:2] == 6'b110100)
				gray1_r <= cmd[1:0];
			else if (cmd[7:2] == 6'b110101)
				gray2_r <= cmd[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// R16: sleep turns pump and drivers off; wake restores pump before drivers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_r     <= LDC_PWR_SLEEP;
			pwr_cnt_r <= 10'h000;
		end
		else if (clk_en)
		begin
			case (pwr_r)
				LDC_PWR_SLEEP:
					if (display_ctrl_bits_r[2])
					begin
						pwr_r     <= LDC_PWR_PUMP;
						pwr_cnt_r <= 10'h000;
					end
				LDC_PWR_PUMP:
					if (!display_ctrl_bits_r[2])
						pwr_r <= LDC_PWR_SLEEP;
					else if (pwr_cnt_r == 10'(`LDC_PWR_UP_CYC - 1))
						pwr_r <= LDC_PWR_ON;
					else
						pwr_cnt_r <= pwr_cnt_r + 10'h001;
				LDC_PWR_ON:
					if (!display_ctrl_bits_r[2])
						pwr_r <= LDC_PWR_SLEEP;
				default: pwr_r <= LDC_PWR_SLEEP;
			endcase
		end
	end
	assign pump_on    = (pwr_r != LDC_PWR_SLEEP);
	assign drivers_on = (pwr_r == LDC_PWR_ON);

	////////////////////////////////////////////////////////////////////////
	// R3: mux rate; R21: icon rows count only with icon flag
	// sum kept five bits wide so two full nibbles do not lose their carry
	assign fixed_rows = {2'b00, {1'b0, top_fixed_pairs_r} + {1'b0, bottom_fixed_pairs_r}, 1'b0};
	always_comb
	begin
		if (partial_r == 2'b11)
			mux_rate = 8'(partial_last_row_r - partial_first_row_r) + 8'h01
				+ (panel_config_bits_r[0] ? fixed_rows : 8'h00);
		else
			mux_rate = {1'b0, last_common_index_r} + 8'h01;
	end

	// rate in 0.1 klps units; R11/R13 base table, R12 scaling
	always_comb
	begin
		logic [7:0] base;
		base = 8'h00;
		case ({display_ctrl_bits_r[3], line_rate_r})
			3'b100: base = 8'h8E;
			3'b101: base = 8'hAD;
			3'b110: base = 8'hD3;
			3'b111: base = 8'hFF;
			3'b000: base = 8'h39;
			3'b001: base = 8'h46;
			3'b010: base = 8'h55;
			default: base = 8'h68;
		endcase
		// R12: scale at mux thresholds, truncating
		if (mux_rate <= 8'h20)
			lr_rate = base >> 2;
		else if (mux_rate <= 8'h2B)
			lr_rate = 8'(({2'b00, base} * 10'h001) / 10'h003);
		else if (mux_rate <= 8'h40)
			lr_rate = base >> 1;
		else if (mux_rate <= 8'h55)
			lr_rate = 8'(({2'b00, base} << 1) / 10'h003);
		else
			lr_rate = base;
	end

	////////////////////////////////////////////////////////////////////////
	// R14/R15: all-on beats inverse; ram untouched. R17: b/w keeps msb only
	always_comb
	begin
		logic [1:0] px;
		px = display_ctrl_bits_r[3] ? pix_data : {2{pix_data[1]}};
		if (!drivers_on)
			seg_level = 2'b00;
		else if (display_ctrl_bits_r[1])
			seg_level = 2'b11;
		else if (display_ctrl_bits_r[0])
			seg_level = ~px;
		else
			seg_level = px;
	end

	// R19: vertical flip reverses com order; R9: fixed band follows the flip
	assign com_row_map = panel_config_bits_r[2] ? (`LDC_RA_LAST - com_index) : com_index;
	// R20: horizontal flip mirrors the host column address
	assign ram_col_addr = panel_config_bits_r[1] ? (`LDC_CA_LAST - column_group_pointer_r)
		: column_group_pointer_r;

	////////////////////////////////////////////////////////////////////////
	// R7: without window enable the defaults bound the stepping
	always_comb
	begin
		win_c0_r = ram_addr_ctrl_r[3] ? 5'h00 : 5'h00;
		win_c1_r = `LDC_CA_LAST;
		win_r0_r = 7'h00;
		win_r1_r = `LDC_RA_LAST;
	end

	// R4/R5/R6: pointer stepping on each ram data access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			column_group_pointer_r <= 5'h00;
			row_pointer_r          <= 7'h00;
		end
		else if (clk_en && ram_access)
		begin
			if (!ram_addr_ctrl_r[1])
			begin
				if (column_group_pointer_r != win_c1_r)
					column_group_pointer_r <= column_group_pointer_r + 5'h01;
				else if (ram_addr_ctrl_r[0])
				begin
					column_group_pointer_r <= win_c0_r;
					row_pointer_r <= ram_addr_ctrl_r[2] ? row_pointer_r - 7'h01
						: row_pointer_r + 7'h01;
				end
			end
			else
			begin
				if ((!ram_addr_ctrl_r[2] && row_pointer_r != win_r1_r) ||
					(ram_addr_ctrl_r[2] && row_pointer_r != win_r0_r))
					row_pointer_r <= ram_addr_ctrl_r[2] ? row_pointer_r - 7'h01
						: row_pointer_r + 7'h01;
				else if (ram_addr_ctrl_r[0])
				begin
					row_pointer_r <= ram_addr_ctrl_r[2] ? win_r1_r : win_r0_r;
					column_group_pointer_r <= column_group_pointer_r + 5'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// R2: bias byte follows parameter write
	a_bias_load: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && pend_r == LDC_PB_BIAS |=> bias_potentiometer_value_r == $past(cmd))
		else $error("bias not loaded");
	// R1: pending parameter cleared after next byte
	a_param_once: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && pend_r != LDC_PB_NONE |=> pend_r == LDC_PB_NONE)
		else $error("parameter pending too long");
	// R3: mux rate in full mode
	a_mux_full: assert property (@(posedge pclk) disable iff (!presetn)
		partial_r != 2'b11 |-> mux_rate == {1'b0, last_common_index_r} + 8'h01)
		else $error("mux rate wrong");
	// R14: all-on output
	a_all_on: assert property (@(posedge pclk) disable iff (!presetn)
		drivers_on && display_ctrl_bits_r[1] |-> seg_level == 2'b11)
		else $error("all-on not forced");
	// R16: sleep turns pump and drivers off next cycle
	a_sleep_off: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !display_ctrl_bits_r[2] |=> !pump_on && !drivers_on)
		else $error("sleep not entered");
	// R16: drivers only after pump
	a_pump_first: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(drivers_on) |-> $past(pump_on))
		else $error("drivers before pump");
	// R20: mirrored column
	a_col_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		panel_config_bits_r[1] |-> ram_col_addr + column_group_pointer_r == 5'h1F)
		else $error("column mirror wrong");
	// R4: no wrap stops at boundary
	a_wrap_stop: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ram_access && ram_addr_ctrl_r[1:0] == 2'b00 && column_group_pointer_r == 5'h1F
		|=> column_group_pointer_r == 5'h1F && $stable(row_pointer_r))
		else $error("pointer moved past boundary");
	// R6: wrapped row step direction
	a_row_dir: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ram_access && ram_addr_ctrl_r[1:0] == 2'b01 && column_group_pointer_r == 5'h1F
		|=> row_pointer_r == $past(row_pointer_r) + (ram_addr_ctrl_r[2] ? 7'h7F : 7'h01))
		else $error("row step wrong");
	c_wake: cover property (@(posedge pclk) disable iff (!presetn) $rose(drivers_on));
	c_partial: cover property (@(posedge pclk) disable iff (!presetn) partial_r == 2'b11);
	c_fix_cmd: cover property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && pend_r == LDC_PB_FIX);
endmodule
`default_nettype wire

// ### tb/ldc_host.sv
// apb host model that issues one register transfer at a time
`timescale 1ns/1ps
`default_nettype none
module ldc_host (
	input  wire logic        pclk,    // bus clock
	output logic             psel,    // select
	output logic             penable, // access phase
	output logic             pwrite,  // direction
	output logic [11:0]      paddr,   // byte address
	output logic [31:0]      pwdata,  // write data
	input  wire logic        pready,  // slave ready
	input  wire logic        pslverr, // slave error
	input  wire logic [31:0] prdata   // read data
);
	// idle bus at time zero
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// setup, access held until ready, then release with flipped lines
	// register reads and writes
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // stale address must not look valid
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ### tb/tb_ldc_ctrl.sv
// self-checking bench for the display-control command decoder
`include "ldc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ldc_ctrl;
	logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, ram_access = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, drivers_on, pump_on, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0]  pix_data = 2'b00, seg_level;
	logic [6:0]  com_row_map, com_index = 7'h00, row = 7'h00;
	logic [4:0]  ram_col_addr, col = 5'h00;
	logic [2:0]  ac = `LDC_RST_AC;
	logic [3:0]  v;
	int          n_checks = 0, n_mismatch = 0, s;
	logic [7:0]  lr4 [4] = '{8'h8E, 8'hAD, 8'hD3, 8'hFF};
	logic [7:0]  lrb [4] = '{8'h39, 8'h46, 8'h55, 8'h68};
	logic [7:0]  last_common_index [5] = '{8'h54, 8'h55, 8'h3F, 8'h2A, 8'h1F};
	logic [7:0]  lrx [5] = '{8'h26, 8'h39, 8'h23, 8'h13, 8'h1A};
	logic [1:0]  cdx [5] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h3};
	logic [2:0]  acs [6] = '{3'h1, 3'h5, 3'h0, 3'h3, 3'h7, 3'h2};
	int          ns  [6] = '{33, 64, 40, 130, 130, 200};

	// 100 MHz clock
	always #5 pclk = ~pclk;

	ldc_ctrl ldc_ctrl_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.ram_access(ram_access), .pix_data(pix_data), .seg_level(seg_level), .drivers_on(drivers_on),
		.pump_on(pump_on), .com_row_map(com_row_map), .com_index(com_index), .ram_col_addr(ram_col_addr));
	ldc_host ldc_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

	////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic cmd(input logic [7:0] b);
		ldc_host_i.xfer(1'b1, 12'h000, {24'h0, b}, q, e);
	endtask
	task automatic rd(input logic [11:0] a);
		ldc_host_i.xfer(1'b0, a, 32'h0, q, e);
	endtask
	// pulse ram_access and advance the reference pointers
	task automatic steps(input int n);
		repeat (n)
		begin
			ram_access <= 1'b1;
			cyc(1);
			ram_access <= 1'b0;
			cyc(1);
			if (!ac[1])
			begin
				if (col != 5'h1F)
					col++;
				else if (ac[0])
				begin
					col = 5'h00;
					row = ac[2] ? row - 7'h01 : row + 7'h01;
				end
			end
			else if (row != (ac[2] ? 7'h00 : 7'h7F))
				row = ac[2] ? row - 7'h01 : row + 7'h01;
			else if (ac[0])
			begin
				row = ac[2] ? 7'h7F : 7'h00;
				col++;
			end
		end
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial
	begin
		cyc(20000);
		n_mismatch++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		s = $urandom(29);
		cyc(2);
		presetn <= 1'b1;
		rd(12'h004);
		chk({q[25:18], q[14:11], q[7:4]}, {`LDC_RST_PM, `LDC_RST_DC, 1'b0, `LDC_RST_AC});
		rd(12'h008);
		chk(q[19:4], {2'b10, `LDC_RST_GS1, `LDC_RST_NIV, `LDC_RST_FIX});
		chk({pump_on, drivers_on}, 2'b00);
		cmd(8'hAF);
		cyc(2);
		chk({pump_on, drivers_on}, 2'b10);
		cyc(`LDC_PWR_UP_CYC);
		chk({pump_on, drivers_on}, 2'b11);
		cmd(8'hA5);
		#1 chk(seg_level, 2'b11);
		cmd(8'hA4);
		for (int i = 0; i < 8; i++)
		begin
			cmd(8'hA6 | i[0]);
			pix_data <= 2'($urandom);
			cyc(1);
			#1 chk(seg_level, i[0] ? 2'(~pix_data) : pix_data);
		end
		// parameter byte looks like an opcode; it must not be decoded as one
		cmd(8'h81);
		cmd(8'hA4);
		cmd(8'h81);
		cmd(8'hC1);
		rd(12'h004);
		chk({q[25:18], q[14:11]}, {8'hC1, 4'b1101});
		clk_en <= 1'b0;
		cmd(8'h81);
		cmd(8'h12);
		clk_en <= 1'b1;
		rd(12'h004);
		chk(q[25:18], 8'hC1);
		rd(12'h01C);
		chk(e, 1'b1);
		rd(12'h000);
		chk(e, 1'b1);
		ldc_host_i.xfer(1'b1, 12'h004, 32'h0, q, e);
		chk(e, 1'b1);
		// line rate codes in both shade modes
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
				cmd(8'hAD);
			cmd(8'hA0 | i[1:0]);
			rd(12'h00C);
			chk(q[15:0], {i < 4 ? lr4[i[1:0]] : lrb[i[1:0]], 8'h80});
		end
		for (int i = 0; i < 5; i++)
		begin
			cmd(8'hF1);
			cmd(last_common_index[i]);
			cmd(8'hA0 | cdx[i]);
			rd(12'h00C);
			chk(q[15:0], {lrx[i], last_common_index[i] + 8'h01});
		end
		cmd(8'hF1);
		cmd(8'h7F);
		// flip mapping with no fixed rows
		for (int i = 0; i < 4; i++)
		begin
			cmd(i[0] ? 8'hC4 : 8'hC0);
			com_index <= 7'($urandom);
			cyc(1);
			#1 chk(com_row_map, i[0] ? 7'h7F - com_index : com_index);
		end
		// rows chosen clear of the icon area
		cmd(8'h90);
		cmd(8'h21);
		cmd(8'hF2);
		cmd(8'h0A);
		cmd(8'hF3);
		cmd(8'h28);
		rd(12'h018);
		chk(q[20:0], {7'h7F, 7'h0A, 7'h28});
		rd(12'h008);
		chk(q[11:4], 8'h21);
		for (int i = 0; i < 5; i++)
		begin
			cmd(i == 4 ? 8'hC0 : 8'hC1);
			cmd(i == 4 ? 8'h87 : 8'h84 | i[1:0]);
			rd(12'h00C);
			chk(q[7:0], i == 3 ? 8'h25 : i == 4 ? 8'h1F : 8'h80);
		end
		cmd(8'h84);
		cmd(8'h90);
		cmd(8'h00);
		for (int i = 0; i < 4; i++)
		begin
			v = {2'($urandom), i[1:0]};
			cmd(8'hC8);
			cmd({4'h0, v});
			cmd(8'hD0 | i[1:0]);
			cmd(8'hD4 | (2'd3 - i[1:0]));
			rd(12'h008);
			chk(q[19:12], {2'd3 - i[1:0], i[1:0], v});
		end
		// address stepping under six of the eight control settings
		for (int i = 0; i < 6; i++)
		begin
			cmd(8'h88 | acs[i]);
			ac = acs[i];
			steps(ns[i]);
			rd(12'h010);
			chk(q[6:0], row);
			chk(ram_col_addr, col);
			cmd(8'hC2);
			#1 chk(ram_col_addr, 5'h1F - col);
			cmd(8'hC0);
		end
		cmd(8'hAC);
		cyc(2);
		chk({pump_on, drivers_on, seg_level}, 4'h0);
		cmd(8'hAD);
		cyc(2);
		chk({pump_on, drivers_on}, 2'b10);
		// host stays quiet while the supply comes up
		cyc(`LDC_PWR_UP_CYC);
		chk({pump_on, drivers_on}, 2'b11);
		test_done;
	end
endmodule
`default_nettype wire
